/* logic/pcr_pkg.sv */
// package: register offsets, field layouts and reset values of the config bank
package pcr_pkg;
    localparam logic [7:0] PCR_ADDR_THERMAL = 8'h0b;
    localparam logic [7:0] PCR_ADDR_TOP_MODE = 8'h0c;
    localparam logic [7:0] PCR_ADDR_WD_CLEAR = 8'h0d;
    localparam logic [7:0] PCR_ADDR_CHARGER_WRITE_KEY = 8'h10;
    localparam logic [7:0] PCR_ADDR_FAST = 8'h11;
    localparam logic [7:0] PCR_ADDR_TOPOFF = 8'h12;
    localparam logic [7:0] PCR_ADDR_PRECHG = 8'h13;
    localparam logic [7:0] PCR_ADDR_DEAD = 8'h14;
    localparam logic [7:0] PCR_ADDR_VOLT = 8'h15;
    localparam logic [7:0] PCR_THERMAL_RST = 8'h0e;
    localparam logic [7:0] PCR_TOP_MODE_RST = 8'h01;
    localparam logic [7:0] PCR_CHARGER_WRITE_KEY_RST = 8'h03;
    localparam logic [7:0] PCR_FAST_RST = 8'h08;
    localparam logic [7:0] PCR_TOPOFF_RST = 8'h04;
    localparam logic [7:0] PCR_PRECHG_RST = 8'h08;
    localparam logic [7:0] PCR_DEAD_RST = 8'h04;
    localparam logic [7:0] PCR_VOLT_RST = 8'h1e;
    localparam int PCR_SHDN_LSB = 2;
    localparam int PCR_WARN_LSB = 0;
    localparam logic [2:0] PCR_SHDN_RSVD = 3'h7;
    localparam int PCR_MODE_LSB = 3;
    localparam int PCR_SWRST_BIT = 2;
    localparam int PCR_GLITCH_LSB = 0;
    localparam logic [2:0] PCR_WD_CLEAR_CODE = 3'h1;
    localparam int PCR_KEY_LSB = 3;
    localparam logic [4:0] PCR_KEY_OPEN = 5'h15;
    localparam int PCR_NTC_BIT = 2;
    localparam int PCR_TIMER_BIT = 1;
    localparam int PCR_CHGEN_BIT = 0;
    localparam int PCR_DTIMER_LSB = 6;
    localparam int PCR_CUR_LSB = 0;
endpackage

/* logic/pcr_bus_if.sv */
// interface: decoded register write strobe between front end and bank
interface pcr_bus_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    modport front (output wr_en, output addr, output wdata);
    modport bank (input wr_en, input addr, input wdata);
endinterface

/* logic/pcr_front.sv */
// module: write front end, drops writes to the charger block while locked
module pcr_front
    import pcr_pkg::*;
(
    input wire logic wr_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [4:0] key_in,
    pcr_bus_if.front bus
);
    wire logic locked_addr;
    wire logic key_open;
    // protected window runs 11h..15h; the key register itself stays open
    assign locked_addr = (addr_in >= PCR_ADDR_FAST) && (addr_in <= PCR_ADDR_VOLT);
    assign key_open = (key_in == PCR_KEY_OPEN);
    assign bus.wr_en = wr_en_in && (!locked_addr || key_open);
    assign bus.addr = addr_in;
    assign bus.wdata = wdata_in;
endmodule // pcr_front

/* logic/pcr_regs.sv */
// module: top-level and charger configuration register bank
//
// How it works
// - 3-bit shutdown threshold, 95..125 C in 5 C steps, 111 reserved, resets 011.
// - 2-bit die warning threshold, 75..90 C, resets to 10.
// - pin select off: mode index comes from two register bits, both reset 0.
// - pin select on: mode index comes from the mode select pins.
// - writing 1 to bit 2 restores all defaults, cycles outputs, self-clears.
// - 2-bit long-press filter time 4..16 s, resets to 01.
// - watchdog clear register is write-only and resets to zero.
// - writing 001 to the clear code restarts watchdog; other values do nothing.
// - key 10101 in bits 7:3 opens charger writes; key resets 00000.
// - any other key ignores writes to protected registers, contents kept.
// - addresses 11h..15h are protected; key and enables register stays writable.
// - bit 2 of charger control enables thermistor control, resets 0.
// - bit 1 enables both safety timers, resets 1.
// - bit 0 enables the linear charger, resets 1.
// - 6-bit fast current code times 5 mA, resets 001000.
// - 6-bit top-off current code times 1 mA, resets 000100.
// - 6-bit pre-charge current code times 1 mA, resets 001000.
// - dead-battery timer in bits 7:6 selects 5..40 s, resets 00.
// - dead-battery current bits 5:0 times 1 mA, resets 000100.
// - reserved bits of the mode register read and write, reset 0.
module pcr_regs
    import pcr_pkg::*;
(
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic ce_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic [1:0] mode_select_pin_in,
    input wire logic pin_mode_select_enable_in,
    output logic [7:0] rdata_out,
    output logic [1:0] mode_out,
    output logic [2:0] shutdown_temperature_out,
    output logic [1:0] die_warning_out,
    output logic [1:0] long_press_filter_time_out,
    output logic soft_reset_out,
    output logic watchdog_restart_out,
    output logic charger_enable_out,
    output logic safety_timers_enable_out,
    output logic thermistor_control_enable_out,
    output logic [5:0] fast_current_code_out,
    output logic [5:0] topoff_current_code_out,
    output logic [5:0] precharge_current_code_out,
    output logic [1:0] dead_battery_timer_code_out,
    output logic [5:0] dead_battery_current_code_out,
    output logic [7:0] charger_voltage_out
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] thermal_reg;
    logic [7:0] top_mode_reg;
    logic [7:0] charger_write_key_reg;
    logic [7:0] fast_reg;
    logic [7:0] topoff_reg;
    logic [7:0] precharge_reg;
    logic [7:0] dead_reg;
    logic [7:0] volt_reg;
    logic [7:0] rdata_reg;
    logic soft_reset_reg;
    logic wd_restart_reg;
    logic [7:0] thermal_next;
    logic [7:0] rdata_next;
    pcr_bus_if bus ();

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    pcr_front u_front (
        .wr_en_in(wr_en_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .key_in(charger_write_key_reg[7:PCR_KEY_LSB]),
        .bus(bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    wire logic wr_thermal = bus.wr_en && hit(bus.addr, PCR_ADDR_THERMAL);
    wire logic wr_mode = bus.wr_en && hit(bus.addr, PCR_ADDR_TOP_MODE);
    wire logic wr_wd = bus.wr_en && hit(bus.addr, PCR_ADDR_WD_CLEAR);
    wire logic wr_lock = bus.wr_en && hit(bus.addr, PCR_ADDR_CHARGER_WRITE_KEY);
    wire logic wr_fast = bus.wr_en && hit(bus.addr, PCR_ADDR_FAST);
    wire logic wr_topoff = bus.wr_en && hit(bus.addr, PCR_ADDR_TOPOFF);
    wire logic wr_prechg = bus.wr_en && hit(bus.addr, PCR_ADDR_PRECHG);
    wire logic wr_dead = bus.wr_en && hit(bus.addr, PCR_ADDR_DEAD);
    wire logic wr_volt = bus.wr_en && hit(bus.addr, PCR_ADDR_VOLT);
    wire logic swrst_req = wr_mode && bus.wdata[PCR_SWRST_BIT];
    // reserved shutdown code is not stored, previous threshold is kept
    wire logic shdn_ok = (bus.wdata[PCR_SHDN_LSB +: 3] != PCR_SHDN_RSVD);
    wire logic wd_hit = wr_wd && (bus.wdata[2:0] == PCR_WD_CLEAR_CODE);

    assign thermal_next = shdn_ok ? bus.wdata : {bus.wdata[7:5], thermal_reg[4:2], bus.wdata[1:0]};

    ////////////////////////////////////////////////////////////////////////////
    // software reset loads defaults on the same edge that takes the write, same as power-on
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            thermal_reg <= PCR_THERMAL_RST;
            top_mode_reg <= PCR_TOP_MODE_RST;
            charger_write_key_reg <= PCR_CHARGER_WRITE_KEY_RST;
            fast_reg <= PCR_FAST_RST;
            topoff_reg <= PCR_TOPOFF_RST;
            precharge_reg <= PCR_PRECHG_RST;
            dead_reg <= PCR_DEAD_RST;
            volt_reg <= PCR_VOLT_RST;
        end
        else if (ce_in)
        begin
            if (swrst_req)
            begin
                thermal_reg <= PCR_THERMAL_RST;
                top_mode_reg <= PCR_TOP_MODE_RST;
                charger_write_key_reg <= PCR_CHARGER_WRITE_KEY_RST;
                fast_reg <= PCR_FAST_RST;
                topoff_reg <= PCR_TOPOFF_RST;
                precharge_reg <= PCR_PRECHG_RST;
                dead_reg <= PCR_DEAD_RST;
                volt_reg <= PCR_VOLT_RST;
            end
            else
            begin
                if (wr_thermal)
                    thermal_reg <= thermal_next;
                if (wr_mode)
                    top_mode_reg <= {bus.wdata[7:3], 1'b0, bus.wdata[1:0]};
                if (wr_lock)
                    charger_write_key_reg <= bus.wdata;
                if (wr_fast)
                    fast_reg <= bus.wdata;
                if (wr_topoff)
                    topoff_reg <= bus.wdata;
                if (wr_prechg)
                    precharge_reg <= bus.wdata;
                if (wr_dead)
                    dead_reg <= bus.wdata;
                if (wr_volt)
                    volt_reg <= bus.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-cycle strobes; watchdog clear has no storage so reads see zero
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            soft_reset_reg <= 1'b0;
            wd_restart_reg <= 1'b0;
        end
        else if (ce_in)
        begin
            soft_reset_reg <= swrst_req;
            wd_restart_reg <= wd_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        case (addr_in)
            PCR_ADDR_THERMAL: rdata_next = thermal_reg;
            PCR_ADDR_TOP_MODE: rdata_next = top_mode_reg;
            PCR_ADDR_CHARGER_WRITE_KEY: rdata_next = charger_write_key_reg;
            PCR_ADDR_FAST: rdata_next = fast_reg;
            PCR_ADDR_TOPOFF: rdata_next = topoff_reg;
            PCR_ADDR_PRECHG: rdata_next = precharge_reg;
            PCR_ADDR_DEAD: rdata_next = dead_reg;
            PCR_ADDR_VOLT: rdata_next = volt_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rdata_reg <= 8'h00;
        else if (ce_in && rd_en_in)
            rdata_reg <= rdata_next;
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rdata_out = rdata_reg;
    assign soft_reset_out = soft_reset_reg;
    assign watchdog_restart_out = wd_restart_reg;
    assign mode_out = pin_mode_select_enable_in ? mode_select_pin_in
                    : top_mode_reg[PCR_MODE_LSB +: 2];
    assign shutdown_temperature_out = thermal_reg[PCR_SHDN_LSB +: 3];
    assign die_warning_out = thermal_reg[PCR_WARN_LSB +: 2];
    assign long_press_filter_time_out = top_mode_reg[PCR_GLITCH_LSB +: 2];
    assign charger_enable_out = charger_write_key_reg[PCR_CHGEN_BIT];
    assign safety_timers_enable_out = charger_write_key_reg[PCR_TIMER_BIT];
    assign thermistor_control_enable_out = charger_write_key_reg[PCR_NTC_BIT];
    assign fast_current_code_out = fast_reg[PCR_CUR_LSB +: 6];
    assign topoff_current_code_out = topoff_reg[PCR_CUR_LSB +: 6];
    // no clamp against the fast code: the host keeps the ordering
    assign precharge_current_code_out = precharge_reg[PCR_CUR_LSB +: 6];
    assign dead_battery_timer_code_out = dead_reg[PCR_DTIMER_LSB +: 2];
    assign dead_battery_current_code_out = dead_reg[PCR_CUR_LSB +: 6];
    assign charger_voltage_out = volt_reg;

    ////////////////////////////////////////////////////////////////////////////
    locked_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_en_in && addr_in == PCR_ADDR_FAST && charger_write_key_reg[7:3] != PCR_KEY_OPEN
        && !swrst_req |=> $stable(fast_reg)) else $error("locked write changed reg");
    open_write_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_en_in && addr_in == PCR_ADDR_FAST && charger_write_key_reg[7:3] == PCR_KEY_OPEN
        |=> fast_reg == $past(wdata_in)) else $error("open write lost");
    swrst_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && swrst_req |=> top_mode_reg == PCR_TOP_MODE_RST
        && charger_write_key_reg == PCR_CHARGER_WRITE_KEY_RST && thermal_reg == PCR_THERMAL_RST
        && fast_reg == PCR_FAST_RST && topoff_reg == PCR_TOPOFF_RST
        && precharge_reg == PCR_PRECHG_RST && dead_reg == PCR_DEAD_RST
        && volt_reg == PCR_VOLT_RST) else $error("soft reset");
    swrst_bit_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !top_mode_reg[PCR_SWRST_BIT]) else $error("reset bit stuck");
    swrst_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in |=> soft_reset_out == $past(swrst_req)) else $error("soft reset pulse");
    wd_pulse_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_en_in && addr_in == PCR_ADDR_WD_CLEAR |=>
        watchdog_restart_out == ($past(wdata_in[2:0]) == PCR_WD_CLEAR_CODE))
        else $error("wd");
    shdn_rsvd_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        shutdown_temperature_out != PCR_SHDN_RSVD) else $error("reserved shutdown");
    shdn_keep_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_thermal && !shdn_ok |=> thermal_reg[4:2] == $past(thermal_reg[4:2]))
        else $error("reserved code stored");
    thermal_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_thermal && shdn_ok |=> thermal_reg == $past(wdata_in))
        else $error("thermal write lost");
    mode_store_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_mode && !swrst_req |=> top_mode_reg == ($past(wdata_in) & 8'hfb))
        else $error("mode write lost");
    mode_src_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        mode_out == (pin_mode_select_enable_in ? mode_select_pin_in : top_mode_reg[4:3]))
        else $error("mode source");
    lock_free_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_en_in && addr_in == PCR_ADDR_CHARGER_WRITE_KEY |=> charger_write_key_reg == $past(wdata_in))
        else $error("key write lost");
    wd_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && rd_en_in && addr_in == PCR_ADDR_WD_CLEAR |=> rdata_out == 8'h00)
        else $error("wd readable");
    read_back_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && rd_en_in && addr_in == PCR_ADDR_FAST |=> rdata_out == $past(fast_reg))
        else $error("read data wrong");
    // a frozen enable must hold the thermal, mode, key and fast registers, read data included
    ce_freeze_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !ce_in |=> $stable(thermal_reg) && $stable(top_mode_reg) && $stable(charger_write_key_reg)
        && $stable(fast_reg) && $stable(rdata_reg)) else $error("enable low changed state");
    rdata_hold_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
        !(ce_in && rd_en_in) |=> $stable(rdata_out)) else $error("read data moved");
    lock_open_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        wr_lock ##2 wr_fast);
    wd_pulse_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        watchdog_restart_out);
    locked_drop_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        ce_in && wr_en_in && !bus.wr_en);
    swrst_c: cover property (@(posedge clk_in) disable iff (!resetn_in) swrst_req);
    pin_mode_c: cover property (@(posedge clk_in) disable iff (!resetn_in)
        pin_mode_select_enable_in && mode_out == 2'h3);
endmodule // pcr_regs

/* bench/pcr_host.sv */
// bench: host side model that issues single register writes and reads
module pcr_host
(
    input wire logic clk_in,
    output logic ce_out,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {ce_out, wr_en_out, rd_en_out, addr_out, wdata_out} = '0;
    // request set on a falling edge, held across the taking rising edge
    task automatic xfer(input logic ce, input logic we, input logic re,
                        input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        {ce_out, wr_en_out, rd_en_out, addr_out, wdata_out} = {ce, we, re, a, d};
        @(negedge clk_in);
        {wr_en_out, rd_en_out} = 2'h0;
        // released bus shows a changed pattern, not the last value
        addr_out = ~a;
        wdata_out = ~d;
    endtask
endmodule // pcr_host

/* bench/tb_pmic_top_and_charger_config_regs.sv */
// bench: self-checking testbench of the configuration register bank
module tb_pmic_top_and_charger_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import pcr_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic pin_en = 1'b0;
    logic [1:0] pins = 2'h0;
    logic ce, wr_en, rd_en, soft_rst, wd_rst, charger_enable, tmr_en, thermistor_control_enable;
    logic [7:0] addr, wdata, rdata, volt;
    logic [1:0] mode, warn, glitch, dtimer;
    logic [2:0] shdn;
    logic [5:0] fast, topoff, prechg, dcur;
    int num_errors = 0;
    int total_checks = 0;
    int seed = 6715;
    int cycles = 0;
    int m [0:255];
    pcr_host i_host (.clk_in(clk_in), .ce_out(ce), .wr_en_out(wr_en), .rd_en_out(rd_en),
        .addr_out(addr), .wdata_out(wdata));
    pcr_regs i_dut (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce), .wr_en_in(wr_en),
        .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .mode_select_pin_in(pins),
        .pin_mode_select_enable_in(pin_en), .rdata_out(rdata), .mode_out(mode),
        .shutdown_temperature_out(shdn), .die_warning_out(warn),
        .long_press_filter_time_out(glitch), .soft_reset_out(soft_rst),
        .watchdog_restart_out(wd_rst), .charger_enable_out(charger_enable),
        .safety_timers_enable_out(tmr_en), .thermistor_control_enable_out(thermistor_control_enable),
        .fast_current_code_out(fast), .topoff_current_code_out(topoff),
        .precharge_current_code_out(prechg), .dead_battery_timer_code_out(dtimer),
        .dead_battery_current_code_out(dcur), .charger_voltage_out(volt));
    always #20 clk_in = ~clk_in;
    // whole run needs well under a thousand cycles
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        if (seen !== exp)
            num_errors++;
    endtask
    function automatic void mreset();
        foreach (m[i]) m[i] = 0;
        m[8'h0b] = PCR_THERMAL_RST;
        m[8'h0c] = PCR_TOP_MODE_RST;
        m[8'h10] = PCR_CHARGER_WRITE_KEY_RST;
        m[8'h11] = PCR_FAST_RST;
        m[8'h12] = PCR_TOPOFF_RST;
        m[8'h13] = PCR_PRECHG_RST;
        m[8'h14] = PCR_DEAD_RST;
        m[8'h15] = PCR_VOLT_RST;
    endfunction
    function automatic void mwrite(input int a, input int d);
        if (a == 8'h0b)
            m[a] = (((d >> 2) & 7) == 7) ? ((d & 8'he3) | (m[a] & 8'h1c)) : d;
        else if (a == 8'h0c && (d & 4) != 0)
            mreset();
        else if (a == 8'h0c)
            m[a] = d & 8'hfb;
        else if (a == 8'h10)
            m[a] = d;
        else if (a > 8'h10 && a < 8'h16 && (m[8'h10] >> 3) == 8'h15)
            m[a] = d;
    endfunction
    task automatic chk_outs();
        chk(8'({shdn, warn}), 8'(m[8'h0b] & 31));
        chk(8'({mode, glitch}), 8'({pin_en ? pins : 2'(m[8'h0c] >> 3), 2'(m[8'h0c])}));
        chk(8'({thermistor_control_enable, tmr_en, charger_enable}), 8'(m[8'h10] & 7));
        chk(8'(fast), 8'(m[8'h11] & 63));
        chk(8'(topoff), 8'(m[8'h12] & 63));
        chk(8'(prechg), 8'(m[8'h13] & 63));
        chk(8'({dtimer, dcur}), 8'(m[8'h14]));
        chk(volt, 8'(m[8'h15]));
    endtask
    task automatic wr(input int a, input int d);
        d = d & 8'hff;
        i_host.xfer(1'b1, 1'b1, 1'b0, 8'(a), 8'(d));
        mwrite(a, d);
        chk_outs();
    endtask
    task automatic rd_all();
        for (int a = 8'h0b; a < 8'h17; a++)
        begin
            i_host.xfer(1'b1, 1'b0, 1'b1, 8'(a), 8'h00);
            chk(rdata, 8'(m[a]));
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int f;
        int p;
        mreset();
        repeat (5) @(negedge clk_in);
        resetn_in = 1'b1;
        chk_outs();
        chk(8'({shdn, warn}), 8'h0e);
        chk(8'({glitch, thermistor_control_enable, tmr_en, charger_enable}), 8'h0b);
        chk(8'(mode), 8'h00);
        chk(8'(fast), 8'h08);
        chk(8'(topoff), 8'h04);
        chk(8'(prechg), 8'h08);
        chk(8'({dtimer, dcur}), 8'h04);
        rd_all();
        // key at reset, then one below the open value, both must lock
        for (int k = 0; k < 2; k++)
        begin
            if (k == 1)
                wr(8'h10, 8'ha0 | ($random(seed) & 7));
            for (int a = 8'h11; a < 8'h16; a++)
                wr(a, $random(seed));
        end
        wr(8'h10, 8'ha8 | ($random(seed) & 7));
        f = $random(seed) & 8'hff;
        wr(8'h11, f);
        p = $unsigned($random(seed)) % ((f & 63) + 1);
        wr(8'h13, p | ($random(seed) & 8'hc0));
        wr(8'h14, ($random(seed) & 8'hc0) | ($unsigned($random(seed)) % (p + 1)));
        wr(8'h12, $random(seed));
        wr(8'h15, $random(seed));
        // enable low: an open-key write and a read must both be lost
        i_host.xfer(1'b0, 1'b1, 1'b1, 8'h11, 8'(m[8'h11]) ^ 8'h3f);
        chk_outs();
        chk(rdata, 8'h00);
        for (int c = 0; c < 8; c++)
            wr(8'h0b, (c << 2) | ($random(seed) & 8'he3));
        for (int c = 0; c < 8; c++)
        begin
            pin_en = c[2];
            pins = 2'($random(seed));
            wr(8'h0c, (c << 3) | ($random(seed) & 8'he3));
        end
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h0d, c);
            chk(8'(wd_rst), 8'(c == 1));
        end
        rd_all();
        i_host.xfer(1'b1, 1'b1, 1'b0, 8'h0c, 8'(8'h04 | ($random(seed) & 8'hfb)));
        chk(8'(soft_rst), 8'h01);
        mreset();
        i_host.xfer(1'b1, 1'b0, 1'b0, 8'h00, 8'h00);
        chk(8'(soft_rst), 8'h00);
        chk_outs();
        rd_all();
        wr(8'h0b, 8'h00);
        resetn_in = 1'b0;
        @(negedge clk_in);
        mreset();
        chk_outs();
        resetn_in = 1'b1;
        rd_all();
        end_of_test();
    end
endmodule // tb_pmic_top_and_charger_config_regs
